// >>> shared/vtec_cfg.svh
// Register offsets, field positions, reset values and timing counts of the transition block.
`ifndef VTEC_CFG_SVH
`define VTEC_CFG_SVH
`define VTEC_ADDR_SRC    12'h000
`define VTEC_ADDR_TRANS  12'h004
`define VTEC_ADDR_CMD    12'h008
`define VTEC_ADDR_STAT   12'h00C
`define VTEC_CMD_FREEZE  0
`define VTEC_CMD_QUAD    1
`define VTEC_CMD_SPLIT   2
`define VTEC_CMD_INSET   3
`define VTEC_CMD_PLUS    4
`define VTEC_CMD_MINUS   5
`define VTEC_CMD_LEFT    6
`define VTEC_CMD_RIGHT   7
`define VTEC_CMD_BDCOL   8
`define VTEC_CMD_BG      9
`define VTEC_CMD_AUTO    10
`define VTEC_CMD_SPD_LO  12
`define VTEC_CMD_POS_LO  16
`define VTEC_CMD_POSVLD  20
`define VTEC_CMD_BDEN    21
`define VTEC_CMD_REMOTE  31
`define VTEC_SRC_BG      3'h4
`define VTEC_RST_MAIN    3'h0
`define VTEC_RST_SUB     3'h1
`define VTEC_RST_POS     4'h8
`define VTEC_POS_CNT     4'h9
`define VTEC_H_ACT       11'd720
`define VTEC_V_ACT       11'd576
`define VTEC_BORDER_W    11'd4
`define VTEC_EDGE_M      11'd8
`define VTEC_CENTRE_M    11'd32
`define VTEC_PROG_MAX    8'hFF
`define VTEC_STEP_SLOW   9'd2
`define VTEC_STEP_MED    9'd5
`define VTEC_STEP_FAST   9'd15
`endif

// >>> shared/vtec_pkg.sv
// Types shared by the transition block.
package vtec_pkg;
  typedef enum logic [1:0] {VTEC_FX_NONE, VTEC_FX_QUAD, VTEC_FX_SPLIT, VTEC_FX_INSET} vtec_fx_t;
  typedef enum logic [1:0] {VTEC_TR_NONE, VTEC_TR_FADE, VTEC_TR_WIPE} vtec_trans_t;
endpackage

// >>> rtl/vtec_sync.sv
// Three-stage synchroniser that passes a word once the second and third stages agree.
`timescale 1ns/10ps
module vtec_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // A word caught mid-change differs between stages and is not passed on.
      if (s2_reg == s3_reg) begin
        q <= s3_reg;
      end
    end
  end
endmodule // vtec_sync

// >>> rtl/vtec_top.sv
// Transition and effect control with program compositing for a four-input switcher.
//
// Function
// R1 - New main source cuts in at once.
// R2 - Fade blends whole picture by one proportion.
// R3 - Eleven wipe patterns are offered.
// R4 - Progress follows lever; end stops are relative.
// R5 - No transition type selected means fade.
// R6 - Auto take only by remote, three speeds.
// R7 - Freeze toggles held frame; works with transitions.
// R8 - Quad shows four inputs; again restores.
// R9 - Quad and inset refuse other transitions, effects.
// R10 - Split halves; left/right swap; buses reselect.
// R11 - Inset shows sub over main; lamp lit.
// R12 - Inset has two sizes via plus/minus.
// R13 - Nine inset positions; corners move edge/centre.
// R14 - Border controls only during wipe or inset.
// R15 - Eight border colours; inset forces white.
// R16 - Background cycles eight colours in order.
// R17 - Background lamp shows colour, dark for black.
// R18 - Lever sampled per frame, linear coefficient.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "vtec_cfg.svh"
module vtec_top (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Manual lever
  input  wire logic [7:0]  LEVER_POS,
  // Video timing and sources
  input  wire logic        VID_SOF,
  input  wire logic        VID_VLD,
  input  wire logic [10:0] VID_X,
  input  wire logic [10:0] VID_Y,
  input  wire logic [23:0] SRC_PIX_0,
  input  wire logic [23:0] SRC_PIX_1,
  input  wire logic [23:0] SRC_PIX_2,
  input  wire logic [23:0] SRC_PIX_3,
  // Program output and lamps
  output logic      [23:0] PGM_PIX,
  output logic             PGM_VLD,
  output logic             FREEZE_MAIN,
  output logic             INSET_LED,
  output logic      [2:0]  BG_LED
);
  import vtec_pkg::*;

  logic [7:0]  lever_s;
  logic        acc;
  logic        wr;
  logic        cmd_wr;
  logic        addr_ok;
  logic [31:0] rd_word;
  logic [2:0]  main_reg;
  logic [2:0]  sub_reg;
  vtec_trans_t ttype_reg;
  logic [3:0]  pat_reg;
  vtec_fx_t    fx_reg;
  logic        swap_reg;
  logic        big_reg;
  logic [3:0]  pos_reg;
  logic        edge_reg;
  logic        bd_en_reg;
  logic [2:0]  bd_col_reg;
  logic [2:0]  bg_col_reg;
  logic [7:0]  prog_reg;
  logic        dir_reg;
  logic        auto_reg;
  logic [8:0]  step_reg;
  logic        lock;
  logic        bd_ok;
  logic [7:0]  lv;
  logic [8:0]  auto_sum;
  logic        done;
  logic [18:0] tx_prod;
  logic [18:0] ty_prod;
  logic [10:0] tx;
  logic [10:0] ty;
  logic [10:0] win_w;
  logic [10:0] win_h;
  logic [10:0] win_x;
  logic [10:0] win_y;
  logic [10:0] marg;
  logic [23:0] pix_a;
  logic [23:0] pix_b;
  logic [23:0] pix_next;

  vtec_sync #(.W(8)) u_lever_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .d     (LEVER_POS),
    .q     (lever_s)
  );

  function automatic logic [2:0] lamp_bits(input logic [2:0] c);
    case (c)
      3'h1:    lamp_bits = 3'h1;
      3'h2:    lamp_bits = 3'h5;
      3'h3:    lamp_bits = 3'h4;
      3'h4:    lamp_bits = 3'h2;
      3'h5:    lamp_bits = 3'h3;
      3'h6:    lamp_bits = 3'h6;
      3'h7:    lamp_bits = 3'h7;
      default: lamp_bits = 3'h0;
    endcase
  endfunction

  function automatic logic [23:0] col_rgb(input logic [2:0] c);
    logic [2:0] b;
    b = lamp_bits(c);
    col_rgb = {{8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  function automatic logic [23:0] pick(input logic [2:0] idx);
    case (idx)
      3'h0:    pick = SRC_PIX_0;
      3'h1:    pick = SRC_PIX_1;
      3'h2:    pick = SRC_PIX_2;
      3'h3:    pick = SRC_PIX_3;
      default: pick = col_rgb(bg_col_reg); // [R16]
    endcase
  endfunction

  function automatic logic [23:0] blend(input logic [23:0] a, input logic [23:0] b,
                                        input logic [7:0] k);
    logic [16:0] acc_v;
    blend = 24'h000000;
    for (int i = 0; i < 3; i++) begin
      // Widen before multiplying so the products keep all sixteen bits.
      acc_v = ({9'h000, a[8*i +: 8]} * (17'h00100 - {9'h000, k})) +
              ({9'h000, b[8*i +: 8]} * {9'h000, k});
      blend[8*i +: 8] = acc_v[15:8];
    end
  endfunction

  // Region in which the incoming source shows, for thresholds tx and ty.
  function automatic logic in_wipe(input logic [3:0] p, input logic [10:0] x,
                                   input logic [10:0] y, input logic [10:0] tw,
                                   input logic [10:0] th);
    logic [10:0] dx;
    logic [10:0] dy;
    dx = (x >= (`VTEC_H_ACT >> 1)) ? x - (`VTEC_H_ACT >> 1) : (`VTEC_H_ACT >> 1) - x;
    dy = (y >= (`VTEC_V_ACT >> 1)) ? y - (`VTEC_V_ACT >> 1) : (`VTEC_V_ACT >> 1) - y;
    case (p)
      4'h0:    in_wipe = ({dx, 1'b0} < {1'b0, tw}) && ({dy, 1'b0} < {1'b0, th});
      4'h1:    in_wipe = (x >= `VTEC_H_ACT - tw) && (y < th);
      4'h2:    in_wipe = !((x < `VTEC_H_ACT - tw) && (y < `VTEC_V_ACT - th));
      4'h3:    in_wipe = (x < tw) && (y < th);
      4'h4:    in_wipe = !((x >= tw) && (y < `VTEC_V_ACT - th));
      4'h5:    in_wipe = y < th;
      4'h6:    in_wipe = y >= `VTEC_V_ACT - th;
      4'h7:    in_wipe = x < tw;
      4'h8:    in_wipe = x >= `VTEC_H_ACT - tw;
      4'h9:    in_wipe = {dx, 1'b0} < {1'b0, tw};
      default: in_wipe = {dy, 1'b0} < {1'b0, th};
    endcase
  endfunction

  assign acc     = PSEL & PENABLE & PREADY;
  assign wr      = acc & PWRITE;
  assign cmd_wr  = wr & (PADDR == `VTEC_ADDR_CMD);
  assign addr_ok = (PADDR == `VTEC_ADDR_SRC) || (PADDR == `VTEC_ADDR_TRANS) ||
                   (PADDR == `VTEC_ADDR_CMD) || (PADDR == `VTEC_ADDR_STAT);
  assign lock    = (fx_reg == VTEC_FX_QUAD) || (fx_reg == VTEC_FX_INSET); // [R9]
  assign bd_ok   = (ttype_reg == VTEC_TR_WIPE) || (fx_reg == VTEC_FX_INSET); // [R14]

  always_comb begin
    case (PADDR)
      `VTEC_ADDR_SRC:   rd_word = {25'h0, sub_reg, 1'b0, main_reg};
      `VTEC_ADDR_TRANS: rd_word = {24'h0, pat_reg, 2'h0, ttype_reg};
      `VTEC_ADDR_STAT:  rd_word = {4'h0, dir_reg, swap_reg, auto_reg, bg_col_reg,
                                   bd_col_reg, bd_en_reg, edge_reg, pos_reg, big_reg,
                                   freeze_bit(FREEZE_MAIN), 1'b0, fx_reg, prog_reg};
      default:          rd_word = 32'h00000000;
    endcase
  end

  function automatic logic freeze_bit(input logic f);
    freeze_bit = f;
  endfunction

  // APB answers in the second cycle of the access phase, after one wait state; unmapped addresses report an error.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
      if (PSEL & PENABLE & ~PREADY) begin
        PRDATA <= PWRITE ? 32'h00000000 : rd_word;
      end
    end
  end

  // Coefficient for the next frame, taken from the lever once per frame.
  assign lv       = dir_reg ? ~lever_s : lever_s; // [R4] [R18]
  assign auto_sum = {1'b0, prog_reg} + step_reg;
  assign done     = !lock && (auto_reg ? (auto_sum >= {1'b0, `VTEC_PROG_MAX})
                                       : (lv == `VTEC_PROG_MAX));

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prog_reg <= 8'h00;
      dir_reg  <= 1'b0;
      auto_reg <= 1'b0;
      step_reg <= `VTEC_STEP_SLOW;
    end else begin
      if (VID_SOF) begin
        if (lock) begin
          prog_reg <= 8'h00; // [R9]
          auto_reg <= 1'b0;
        end else if (done) begin
          prog_reg <= 8'h00;
          auto_reg <= 1'b0;
          // A finished manual move leaves the lever at the new relative start.
          if (!auto_reg) begin
            dir_reg <= ~dir_reg; // [R4]
          end
        end else if (auto_reg) begin
          prog_reg <= auto_sum[7:0]; // [R6]
        end else begin
          prog_reg <= lv; // [R18]
        end
      end
      // A take in the cycle of a completion must not be lost, so the set comes last.
      if (cmd_wr && PWDATA[`VTEC_CMD_AUTO] && PWDATA[`VTEC_CMD_REMOTE] && !lock) begin
        auto_reg <= 1'b1; // [R6]
        case (PWDATA[`VTEC_CMD_SPD_LO +: 2])
          2'h0:    step_reg <= `VTEC_STEP_SLOW;
          2'h1:    step_reg <= `VTEC_STEP_MED;
          default: step_reg <= `VTEC_STEP_FAST;
        endcase
      end
    end
  end

  // Source buses; a completed transition exchanges main and sub.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      main_reg  <= `VTEC_RST_MAIN;
      sub_reg   <= `VTEC_RST_SUB;
      ttype_reg <= VTEC_TR_NONE;
      pat_reg   <= 4'h0;
    end else begin
      if (VID_SOF && done) begin
        main_reg <= sub_reg;
        sub_reg  <= main_reg;
      end
      if (wr && PADDR == `VTEC_ADDR_SRC) begin
        if (PWDATA[2:0] <= `VTEC_SRC_BG) begin
          main_reg <= PWDATA[2:0]; // [R1] [R10]
        end
        if (PWDATA[6:4] <= `VTEC_SRC_BG) begin
          sub_reg <= PWDATA[6:4]; // [R10]
        end
      end
      if (wr && PADDR == `VTEC_ADDR_TRANS && !lock) begin
        if (PWDATA[1:0] != 2'h3) begin
          ttype_reg <= vtec_trans_t'(PWDATA[1:0]);
        end
        if (PWDATA[7:4] <= 4'hA) begin
          pat_reg <= PWDATA[7:4]; // [R3]
        end
      end
    end
  end

  // Panel commands for effects, freeze, border and background.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fx_reg      <= VTEC_FX_NONE;
      FREEZE_MAIN <= 1'b0;
      swap_reg    <= 1'b0;
      big_reg     <= 1'b0;
      pos_reg     <= `VTEC_RST_POS;
      edge_reg    <= 1'b0;
      bd_en_reg   <= 1'b0;
      bd_col_reg  <= 3'h0;
      bg_col_reg  <= 3'h0;
    end else if (cmd_wr) begin
      if (PWDATA[`VTEC_CMD_QUAD] && (fx_reg == VTEC_FX_NONE || fx_reg == VTEC_FX_QUAD)) begin
        fx_reg <= (fx_reg == VTEC_FX_QUAD) ? VTEC_FX_NONE : VTEC_FX_QUAD; // [R8] [R9]
      end else if (PWDATA[`VTEC_CMD_INSET] &&
                   (fx_reg == VTEC_FX_NONE || fx_reg == VTEC_FX_INSET)) begin
        fx_reg <= (fx_reg == VTEC_FX_INSET) ? VTEC_FX_NONE : VTEC_FX_INSET; // [R11] [R9]
      end else if (PWDATA[`VTEC_CMD_SPLIT] && !lock) begin
        fx_reg   <= (fx_reg == VTEC_FX_SPLIT) ? VTEC_FX_NONE : VTEC_FX_SPLIT; // [R10]
        swap_reg <= 1'b0;
      end
      if (PWDATA[`VTEC_CMD_FREEZE] && !lock) begin
        FREEZE_MAIN <= ~FREEZE_MAIN; // [R7] [R9]
      end
      if (PWDATA[`VTEC_CMD_PLUS]) begin
        big_reg <= 1'b1; // [R12]
      end else if (PWDATA[`VTEC_CMD_MINUS]) begin
        big_reg <= 1'b0; // [R12]
      end
      if (PWDATA[`VTEC_CMD_POSVLD] && PWDATA[`VTEC_CMD_POS_LO +: 4] < `VTEC_POS_CNT) begin
        pos_reg <= PWDATA[`VTEC_CMD_POS_LO +: 4]; // [R13]
      end
      // Left and right mean side swap in split and edge or centre for the inset.
      if (PWDATA[`VTEC_CMD_RIGHT]) begin
        swap_reg <= 1'b1; // [R10]
        edge_reg <= 1'b1; // [R13]
      end else if (PWDATA[`VTEC_CMD_LEFT]) begin
        swap_reg <= 1'b0; // [R10]
        edge_reg <= 1'b0; // [R13]
      end
      if (bd_ok && PWDATA[`VTEC_CMD_BDCOL]) begin
        bd_col_reg <= bd_col_reg + 3'h1; // [R14] [R15]
      end
      if (bd_ok && PWDATA[`VTEC_CMD_BDEN]) begin
        bd_en_reg <= ~bd_en_reg; // [R14]
      end
      if (PWDATA[`VTEC_CMD_BG]) begin
        bg_col_reg <= bg_col_reg + 3'h1; // [R16]
      end
    end
  end

  // Frame-constant wipe thresholds, stable because the coefficient moves only at frame start; the inset window follows panel writes.
  assign tx_prod = prog_reg * `VTEC_H_ACT;
  assign ty_prod = prog_reg * `VTEC_V_ACT;
  assign tx      = tx_prod[18:8];
  assign ty      = ty_prod[18:8];
  assign win_w   = big_reg ? (`VTEC_H_ACT >> 1) : (`VTEC_H_ACT >> 2); // [R12]
  assign win_h   = big_reg ? (`VTEC_V_ACT >> 1) : (`VTEC_V_ACT >> 2);
  assign marg    = (edge_reg && pos_reg != 4'h1 && pos_reg != 4'h3 && pos_reg != 4'h5 &&
                    pos_reg != 4'h7) ? `VTEC_EDGE_M : `VTEC_CENTRE_M; // [R13]

  always_comb begin
    case (pos_reg)
      4'h0, 4'h3, 4'h6: win_x = marg;
      4'h2, 4'h5, 4'h8: win_x = `VTEC_H_ACT - win_w - marg;
      default:          win_x = (`VTEC_H_ACT - win_w) >> 1;
    endcase
    case (pos_reg)
      4'h0, 4'h1, 4'h2: win_y = marg;
      4'h6, 4'h7, 4'h8: win_y = `VTEC_V_ACT - win_h - marg;
      default:          win_y = (`VTEC_V_ACT - win_h) >> 1;
    endcase
  end

  assign pix_a = pick(main_reg);
  assign pix_b = pick(sub_reg);

  always_comb begin
    pix_next = pix_a;
    case (fx_reg)
      VTEC_FX_QUAD: begin
        pix_next = pick({1'b0, VID_Y >= (`VTEC_V_ACT >> 1), VID_X >= (`VTEC_H_ACT >> 1)}); // [R8]
      end
      VTEC_FX_SPLIT: begin
        pix_next = ((VID_X < (`VTEC_H_ACT >> 1)) ^ swap_reg) ? pix_a : pix_b; // [R10]
      end
      VTEC_FX_INSET: begin
        if (VID_X >= win_x && VID_X < win_x + win_w && VID_Y >= win_y &&
            VID_Y < win_y + win_h) begin
          pix_next = pix_b; // [R11]
        end else if (bd_en_reg && VID_X + `VTEC_BORDER_W >= win_x &&
                     VID_X < win_x + win_w + `VTEC_BORDER_W &&
                     VID_Y + `VTEC_BORDER_W >= win_y &&
                     VID_Y < win_y + win_h + `VTEC_BORDER_W) begin
          pix_next = col_rgb(3'h7); // [R15]
        end
      end
      default: begin
        if (prog_reg == 8'h00) begin
          pix_next = pix_a; // [R1]
        end else if (ttype_reg != VTEC_TR_WIPE) begin
          pix_next = blend(pix_a, pix_b, prog_reg); // [R2] [R5]
        end else if (in_wipe(pat_reg, VID_X, VID_Y, tx, ty)) begin
          pix_next = pix_b; // [R3]
        end else if (bd_en_reg && in_wipe(pat_reg, VID_X, VID_Y, tx + `VTEC_BORDER_W,
                                          ty + `VTEC_BORDER_W)) begin
          pix_next = col_rgb(bd_col_reg); // [R15]
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PGM_PIX   <= 24'h000000;
      PGM_VLD   <= 1'b0;
      INSET_LED <= 1'b0;
      BG_LED    <= 3'h0;
    end else begin
      PGM_VLD   <= VID_VLD;
      INSET_LED <= (fx_reg == VTEC_FX_INSET); // [R11]
      BG_LED    <= lamp_bits(bg_col_reg); // [R17]
      if (VID_VLD) begin
        PGM_PIX <= pix_next;
      end
    end
  end
endmodule // vtec_top

// >>> bench/vtec_top_properties.sv
// Concurrent checks on the ports of the transition block.
`timescale 1ns/10ps
`include "vtec_cfg.svh"
module vtec_top_props (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Video and lamps
  input wire logic        VID_VLD,
  input wire logic        PGM_VLD,
  input wire logic [23:0] PGM_PIX,
  input wire logic        FREEZE_MAIN,
  input wire logic        INSET_LED,
  input wire logic [2:0]  BG_LED
);
  logic [2:0] cmd_bits;
  // A lamp may lag its command by one register stage, so causes are sought two deep.
  assign cmd_bits = (PSEL && PENABLE && PREADY && PWRITE && PADDR == `VTEC_ADDR_CMD) ?
                    {PWDATA[9], PWDATA[3], PWDATA[0]} : 3'h0;
  function automatic logic [2:0] bg_next(input logic [2:0] c);
    case (c)
      3'h0:    return 3'h1;
      3'h1:    return 3'h5;
      3'h5:    return 3'h4;
      3'h4:    return 3'h2;
      3'h2:    return 3'h3;
      3'h3:    return 3'h6;
      3'h6:    return 3'h7;
      default: return 3'h0;
    endcase
  endfunction
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_ready_wait: assert property ((PSEL && !PENABLE) |=> !PREADY ##1 PREADY)
    else $error("APB answer not after one wait state.");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("PREADY high for more than one cycle.");
  a_error_answer: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("PSLVERR outside an answer.");
  a_valid_delay: assert property (1'b1 |=> PGM_VLD == $past(VID_VLD))
    else $error("PGM_VLD not one cycle after VID_VLD.");
  a_pixel_hold: assert property (!VID_VLD |=> $stable(PGM_PIX))
    else $error("PGM_PIX moved without a pixel.");
  a_freeze_cause: assert property (
    $changed(FREEZE_MAIN) |-> $past(cmd_bits[0]) || $past(cmd_bits[0], 2))
    else $error("Freeze changed without a press.");
  a_inset_cause: assert property (
    $changed(INSET_LED) |-> $past(cmd_bits[1]) || $past(cmd_bits[1], 2))
    else $error("Inset lamp changed without a press.");
  a_bg_order: assert property (
    $changed(BG_LED) |-> BG_LED == bg_next($past(BG_LED))
                         && ($past(cmd_bits[2]) || $past(cmd_bits[2], 2)))
    else $error("Background lamp out of order.");
endmodule // vtec_top_props

bind vtec_top vtec_top_props u_props (
  .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .VID_VLD(VID_VLD),
  .PGM_VLD(PGM_VLD), .PGM_PIX(PGM_PIX), .FREEZE_MAIN(FREEZE_MAIN), .INSET_LED(INSET_LED),
  .BG_LED(BG_LED)
);

// >>> bench/vtec_panel.sv
// Operator panel and remote controller model: APB master and lever.
`timescale 1ns/10ps
`include "vtec_cfg.svh"
module vtec_panel (
  // Clock
  input  wire logic        clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Lever
  output logic      [7:0]  lever_pos
);
  initial begin
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    lever_pos = 8'h00;
  end
  // The request is held until the edge that samples pready; no wait count is assumed.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic remote_take(input logic [1:0] speed);
    logic [31:0] rd;
    logic        er;
    xfer(1'b1, `VTEC_ADDR_CMD, {1'b1, 17'h00000, speed, 2'b01, 10'h000}, rd, er);
  endtask
  task automatic set_lever(input logic [7:0] v);
    @(posedge clk);
    lever_pos <= v;
  endtask
endmodule // vtec_panel

// >>> bench/vtec_top_tb.sv
// Self-checking bench for the transition and effect control block.
`timescale 1ns/10ps
`include "vtec_cfg.svh"
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
  end \
end
module vtec_top_tb;
  logic        CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [7:0]  LEVER_POS;
  logic        VID_SOF = 1'b0;
  logic        VID_VLD = 1'b0;
  logic [10:0] VID_X = 11'h000;
  logic [10:0] VID_Y = 11'h000;
  logic [23:0] PGM_PIX;
  logic        PGM_VLD, FREEZE_MAIN, INSET_LED;
  logic [2:0]  BG_LED;
  logic [23:0] pix [4] = '{24'h102030, 24'h405060, 24'h708090, 24'hA0B0C0};
  logic [2:0]  lamp [8] = '{3'h1, 3'h5, 3'h4, 3'h2, 3'h3, 3'h6, 3'h7, 3'h0};
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #5 CLK = ~CLK;
  vtec_top dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LEVER_POS(LEVER_POS), .VID_SOF(VID_SOF), .VID_VLD(VID_VLD), .VID_X(VID_X), .VID_Y(VID_Y),
    .SRC_PIX_0(pix[0]), .SRC_PIX_1(pix[1]), .SRC_PIX_2(pix[2]), .SRC_PIX_3(pix[3]),
    .PGM_PIX(PGM_PIX), .PGM_VLD(PGM_VLD), .FREEZE_MAIN(FREEZE_MAIN), .INSET_LED(INSET_LED),
    .BG_LED(BG_LED));
  vtec_panel u_panel (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR),
    .lever_pos(LEVER_POS));
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  function automatic logic [23:0] mix(input logic [23:0] a, input logic [23:0] b, input int k);
    int t;
    for (int i = 0; i < 3; i++) begin
      t = (int'(a[i*8+:8]) * (256 - k) + int'(b[i*8+:8]) * k) >> 8;
      mix[i*8+:8] = t[7:0];
    end
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_panel.xfer(1'b1, a, d, rdat, err);
    repeat (2) @(posedge CLK);
  endtask
  task automatic rd(input logic [11:0] a);
    u_panel.xfer(1'b0, a, 32'h0000_0000, rdat, err);
  endtask
  task automatic sof();
    repeat (6) @(posedge CLK);
    VID_SOF <= 1'b1;
    @(posedge CLK);
    VID_SOF <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic px(input logic [10:0] x, input logic [10:0] y);
    @(posedge CLK);
    VID_VLD <= 1'b1;
    VID_X   <= x;
    VID_Y   <= y;
    @(posedge CLK);
    VID_VLD <= 1'b0;
    @(negedge CLK);
  endtask
  task automatic t_regs_cut();
    rd(`VTEC_ADDR_SRC);
    `CHK(rdat, 32'h0000_0010)
    rd(`VTEC_ADDR_STAT);
    `CHK(rdat & 32'hFFFD_FFFF, 32'h0001_0000)
    rd(12'h010);
    `CHK({err, rdat}, {1'b1, 32'h0000_0000})
    wr(`VTEC_ADDR_SRC, 32'h0000_0012);
    px(11'h00A, 11'h00A);
    `CHK(PGM_PIX, pix[2])
    `CHK(PGM_VLD, 1'b1)
  endtask
  task automatic t_lever();
    u_panel.set_lever(8'h80);
    sof();
    u_panel.set_lever(8'h40);
    px(11'h00A, 11'h00A);
    `CHK(PGM_PIX, mix(pix[2], pix[1], 128))
    px(11'h2C0, 11'h200);
    `CHK(PGM_PIX, mix(pix[2], pix[1], 128))
    rd(`VTEC_ADDR_STAT);
    `CHK(rdat[7:0], 8'h80)
    u_panel.set_lever(8'hFF);
    sof();
    rd(`VTEC_ADDR_SRC);
    `CHK(rdat, 32'h0000_0021)
    rd(`VTEC_ADDR_STAT);
    `CHK({rdat[27], rdat[7:0]}, 9'h100)
  endtask
  task automatic t_auto();
    wr(`VTEC_ADDR_CMD, 32'h0000_2400);
    sof();
    rd(`VTEC_ADDR_STAT);
    `CHK(rdat[25], 1'b0)
    u_panel.remote_take(2'h2);
    sof();
    rd(`VTEC_ADDR_STAT);
    `CHK({rdat[25], rdat[7:0]}, 9'h10F)
    repeat (16) sof();
    rd(`VTEC_ADDR_SRC);
    `CHK(rdat, 32'h0000_0012)
  endtask
  task automatic t_quad();
    wr(`VTEC_ADDR_CMD, 32'h0000_0002);
    px(11'h190, 11'h12C);
    `CHK(PGM_PIX, pix[3])
    px(11'h190, 11'h00A);
    `CHK(PGM_PIX, pix[1])
    wr(`VTEC_ADDR_TRANS, 32'h0000_0002);
    wr(`VTEC_ADDR_CMD, 32'h0000_000C);
    rd(`VTEC_ADDR_TRANS);
    `CHK(rdat, 32'h0000_0000)
    rd(`VTEC_ADDR_STAT);
    `CHK(rdat[9:8], 2'h1)
    wr(`VTEC_ADDR_CMD, 32'h0000_0002);
    px(11'h00A, 11'h00A);
    `CHK(PGM_PIX, pix[2])
  endtask
  task automatic t_split();
    wr(`VTEC_ADDR_CMD, 32'h0000_0004);
    px(11'h00A, 11'h00A);
    `CHK(PGM_PIX, pix[2])
    px(11'h190, 11'h00A);
    `CHK(PGM_PIX, pix[1])
    wr(`VTEC_ADDR_CMD, 32'h0000_0080);
    wr(`VTEC_ADDR_SRC, 32'h0000_0003);
    px(11'h00A, 11'h00A);
    `CHK(PGM_PIX, pix[0])
    wr(`VTEC_ADDR_SRC, 32'h0000_0012);
    wr(`VTEC_ADDR_CMD, 32'h0000_0004);
  endtask
  task automatic t_inset();
    wr(`VTEC_ADDR_CMD, 32'h0000_0008);
    `CHK(INSET_LED, 1'b1)
    wr(`VTEC_ADDR_CMD, 32'h0000_0010);
    rd(`VTEC_ADDR_STAT);
    `CHK(rdat[12], 1'b1)
    wr(`VTEC_ADDR_CMD, 32'h0000_0020);
    wr(`VTEC_ADDR_CMD, 32'h0010_0000);
    wr(`VTEC_ADDR_CMD, 32'h0000_0080);
    wr(`VTEC_ADDR_CMD, 32'h0020_0000);
    rd(`VTEC_ADDR_STAT);
    `CHK(rdat[18:12], 7'h60)
    px(11'h014, 11'h014);
    `CHK(PGM_PIX, pix[1])
    px(11'h005, 11'h014);
    `CHK(PGM_PIX, 24'hFFFFFF)
    wr(`VTEC_ADDR_CMD, 32'h0000_0008);
    `CHK(INSET_LED, 1'b0)
  endtask
  task automatic t_border_wipe();
    wr(`VTEC_ADDR_CMD, 32'h0020_0000);
    rd(`VTEC_ADDR_STAT);
    `CHK(rdat[18], 1'b1)
    wr(`VTEC_ADDR_TRANS, 32'h0000_0072);
    wr(`VTEC_ADDR_CMD, 32'h0000_0100);
    rd(`VTEC_ADDR_STAT);
    `CHK(rdat[21:18], 4'h3)
    for (int i = 0; i < 12; i++) begin
      wr(`VTEC_ADDR_TRANS, {24'h000000, i[3:0], 4'h2});
      rd(`VTEC_ADDR_TRANS);
      `CHK(rdat[7:4], (i < 11) ? i[3:0] : 4'hA)
    end
    u_panel.set_lever(8'h7F);
    sof();
    px(11'h00A, 11'h120);
    `CHK(PGM_PIX, pix[1])
    px(11'h00A, 11'h08F);
    `CHK(PGM_PIX, 24'h0000FF)
    px(11'h00A, 11'h00A);
    `CHK(PGM_PIX, pix[2])
  endtask
  task automatic t_freeze_bg();
    wr(`VTEC_ADDR_CMD, 32'h0000_0001);
    `CHK(FREEZE_MAIN, 1'b1)
    wr(`VTEC_ADDR_CMD, 32'h0000_0001);
    `CHK(FREEZE_MAIN, 1'b0)
    for (int i = 0; i < 8; i++) begin
      wr(`VTEC_ADDR_CMD, 32'h0000_0200);
      `CHK(BG_LED, lamp[i])
      rd(`VTEC_ADDR_STAT);
      `CHK(rdat[24:22], 3'(i + 1))
    end
  endtask
  initial begin
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    t_regs_cut();
    t_lever();
    t_auto();
    t_quad();
    t_split();
    t_inset();
    t_border_wipe();
    t_freeze_bg();
    end_of_test();
  end
endmodule // vtec_top_tb
